// >>> core/lrc_pkg.sv
package lrc_pkg;
  // register port geometry: link number in addr[10:8], offset in addr[7:0]
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  localparam int LINK_SHIFT = 8;
  localparam int MAX_LINKS = 8;

  // per-link register offsets
  localparam logic [7:0] OFS_TEMPLATE_ACCESS = 8'h25;
  localparam logic [7:0] OFS_TEMPLATE_WRITE_DATA = 8'h26;
  localparam logic [7:0] OFS_RX_JITTER_ATTEN_CONFIG = 8'h27;
  localparam logic [7:0] OFS_RX_PATH_CONFIG_0 = 8'h28;
  localparam logic [7:0] OFS_RX_PATH_CONFIG_1 = 8'h29;
  localparam logic [7:0] OFS_RX_PATH_CONFIG_2 = 8'h2a;
  localparam logic [7:0] OFS_LOOPBACK_CONTROL = 8'h2b;
  localparam logic [7:0] OFS_RX_POINTER_GAP = 8'h39;
  localparam logic [7:0] OFS_TEMPLATE_READ_DATA = 8'h3f;

  // template access fields
  localparam int TA_ENABLE = 7;
  localparam int TA_DIR = 6;
  localparam int TA_UI_LSB = 4;
  localparam int TA_SAMP_LSB = 0;
  localparam int UI_W = 2;
  localparam int SAMP_W = 4;
  localparam int TEMPLATE_W = 7;

  // jitter attenuator fields
  localparam int JA_REPORT_PEAK = 5;
  localparam int JA_WIDEN = 4;
  localparam int JA_ENABLE = 3;
  localparam int JA_DEPTH_LSB = 1;
  localparam int JA_CORNER = 0;
  localparam logic [1:0] DEPTH_128 = 2'h0;
  localparam logic [1:0] DEPTH_64 = 2'h1;
  localparam logic [6:0] GAP_TOP_128 = 7'h7f;
  localparam logic [6:0] GAP_TOP_64 = 7'h3f;
  localparam logic [6:0] GAP_TOP_32 = 7'h1f;
  localparam logic [6:0] MARGIN_128 = 7'h04;
  localparam logic [6:0] MARGIN_64 = 7'h03;
  localparam logic [6:0] MARGIN_32 = 7'h02;

  // receive path fields
  localparam int RX_POWER_OFF = 4;
  localparam int RX_LINECODE = 0;
  localparam int RX_EQUALIZER_ENABLE = 6;
  localparam int LOS_THR_LSB = 0;
  localparam int LOS_THR_W = 5;
  localparam int SLICE_LSB = 4;
  localparam int PEAK_WIN_LSB = 2;
  localparam int MON_GAIN_LSB = 0;

  // loss-of-signal threshold mapping, dB below nominal
  localparam logic [5:0] LOS_DB_BASE = 6'h04;
  localparam logic [4:0] LOS_CODE_FLOOR = 5'h16;
  localparam logic [5:0] LOS_DB_FLOOR = 6'h30;

  // loopback fields
  localparam int LB_DIGITAL1 = 6;
  localparam int LB_SYS_LOCAL = 5;
  localparam int LB_SYS_REMOTE = 4;
  localparam int LB_LINE_REMOTE = 2;

  // reset values
  localparam logic [7:0] RST_TEMPLATE_ACCESS = 8'h00;
  localparam logic [7:0] RST_TEMPLATE_WRITE_DATA = 8'h00;
  localparam logic [7:0] RST_RX_JITTER_ATTEN_CONFIG = 8'h00;
  localparam logic [7:0] RST_RX_PATH_CONFIG_0 = 8'h00;
  localparam logic [7:0] RST_RX_PATH_CONFIG_1 = 8'h15;
  localparam logic [7:0] RST_RX_PATH_CONFIG_2 = 8'h18;
  localparam logic [7:0] RST_LOOPBACK_CONTROL = 8'h00;

  // writable bits; everything else reads zero
  localparam logic [7:0] MASK_TEMPLATE_ACCESS = 8'hff;
  localparam logic [7:0] MASK_TEMPLATE_WRITE_DATA = 8'h7f;
  localparam logic [7:0] MASK_RX_JITTER_ATTEN_CONFIG = 8'h3f;
  localparam logic [7:0] MASK_RX_PATH_CONFIG_0 = 8'h11;
  localparam logic [7:0] MASK_RX_PATH_CONFIG_1 = 8'h5f;
  localparam logic [7:0] MASK_RX_PATH_CONFIG_2 = 8'h3f;
  localparam logic [7:0] MASK_LOOPBACK_CONTROL = 8'h74;

  localparam logic [3:0] PULSE_ARBITRARY_HI = 4'hc;
  localparam int LOS_CNT_W = 11;
endpackage

// >>> core/lrc_regs.sv
// The plain strobed port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module lrc_regs
  import lrc_pkg::*;
#(
  parameter int LINKS = MAX_LINKS,
  parameter int LOS_INTERVALS = 175,
  parameter logic [5:0] SHORT_HAUL_LOSS_DB = 6'h14
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [DATA_W-1:0] rdata,
  input wire logic [LINKS-1:0][3:0] pulse_shape_sel,
  input wire logic [LINKS-1:0][6:0] rx_fifo_distance,
  input wire logic [LINKS-1:0][5:0] rx_level_db,
  input wire logic [LINKS-1:0] pulse_tick,
  output logic [LINKS-1:0] rx_atten_enable,
  output logic [LINKS-1:0][1:0] rx_atten_depth,
  output logic [LINKS-1:0] rx_atten_corner,
  output logic [LINKS-1:0] rx_atten_wide_now,
  output logic [LINKS-1:0] rx_power_down,
  output logic [LINKS-1:0] rx_linecode_sel,
  output logic [LINKS-1:0] equalizer_enable,
  output logic [LINKS-1:0][5:0] los_threshold_db,
  output logic [LINKS-1:0] loss_of_signal,
  output logic [LINKS-1:0][1:0] slicer_level,
  output logic [LINKS-1:0][1:0] peak_window,
  output logic [LINKS-1:0][1:0] monitor_gain,
  output logic [LINKS-1:0] local_digital_loop1,
  output logic [LINKS-1:0] system_local_loop,
  output logic [LINKS-1:0] system_remote_loop,
  output logic [LINKS-1:0] line_remote_loop
);

  if (LINKS < 1 || LINKS > MAX_LINKS) begin : g_bad_links
    $error("LINKS must be 1..8");
  end
  if (LOS_INTERVALS < 1 || LOS_INTERVALS >= (1 << LOS_CNT_W)) begin : g_bad_los
    $error("LOS_INTERVALS out of range");
  end

  localparam logic [LOS_CNT_W-1:0] LOS_LIMIT = LOS_CNT_W'(LOS_INTERVALS);
  localparam int RAM_DEPTH = MAX_LINKS << (UI_W + SAMP_W);

  logic [7:0] template_access [MAX_LINKS];
  logic [7:0] template_write_data [MAX_LINKS];
  logic [7:0] rx_jitter_atten_config [MAX_LINKS];
  logic [7:0] rx_path_config_0 [MAX_LINKS];
  logic [7:0] rx_path_config_1 [MAX_LINKS];
  logic [7:0] rx_path_config_2 [MAX_LINKS];
  logic [7:0] loopback_control [MAX_LINKS];
  logic [6:0] rx_pointer_gap [MAX_LINKS];
  logic [6:0] template_read_data [MAX_LINKS];
  logic [TEMPLATE_W-1:0] template_ram [RAM_DEPTH];

  logic [2:0] acc_link;
  logic [7:0] acc_ofs;
  logic link_ok;

  assign acc_link = addr[ADDR_W-1:LINK_SHIFT];
  assign acc_ofs = addr[LINK_SHIFT-1:0];
  assign link_ok = 32'(acc_link) < LINKS;

  // template access: fires on the write that sets the enable bit while the link's pulse shape select has both bits of PULSE_ARBITRARY_HI set
  logic tmpl_fire;
  logic tmpl_read;
  logic [UI_W+SAMP_W+2:0] tmpl_index;

  assign tmpl_fire = wr && link_ok && acc_ofs == OFS_TEMPLATE_ACCESS && wdata[TA_ENABLE]
    && ((pulse_shape_sel[acc_link] & PULSE_ARBITRARY_HI) == PULSE_ARBITRARY_HI);
  assign tmpl_read = wdata[TA_DIR];
  assign tmpl_index = {acc_link, wdata[TA_UI_LSB +: UI_W], wdata[TA_SAMP_LSB +: SAMP_W]};

  // ram has no reset: contents are undefined until software loads a template
  always_ff @(posedge clk) begin
    if (tmpl_fire && !tmpl_read) begin
      template_ram[tmpl_index] <= template_write_data[acc_link][TEMPLATE_W-1:0];
    end
  end

  for (genvar n = 0; n < MAX_LINKS; n++) begin : g_link
    logic hit;
    assign hit = wr && link_ok && 32'(acc_link) == n;

    if (n < LINKS) begin : g_live
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          template_access[n] <= RST_TEMPLATE_ACCESS;
          template_write_data[n] <= RST_TEMPLATE_WRITE_DATA;
          rx_jitter_atten_config[n] <= RST_RX_JITTER_ATTEN_CONFIG;
          rx_path_config_0[n] <= RST_RX_PATH_CONFIG_0;
          rx_path_config_1[n] <= RST_RX_PATH_CONFIG_1;
          rx_path_config_2[n] <= RST_RX_PATH_CONFIG_2;
          loopback_control[n] <= RST_LOOPBACK_CONTROL;
        end else if (hit) begin
          case (acc_ofs)
            OFS_TEMPLATE_ACCESS: template_access[n] <= wdata & MASK_TEMPLATE_ACCESS;
            OFS_TEMPLATE_WRITE_DATA: begin
              template_write_data[n] <= wdata & MASK_TEMPLATE_WRITE_DATA;
            end
            OFS_RX_JITTER_ATTEN_CONFIG: begin
              rx_jitter_atten_config[n] <= wdata & MASK_RX_JITTER_ATTEN_CONFIG;
            end
            OFS_RX_PATH_CONFIG_0: rx_path_config_0[n] <= wdata & MASK_RX_PATH_CONFIG_0;
            OFS_RX_PATH_CONFIG_1: rx_path_config_1[n] <= wdata & MASK_RX_PATH_CONFIG_1;
            OFS_RX_PATH_CONFIG_2: rx_path_config_2[n] <= wdata & MASK_RX_PATH_CONFIG_2;
            OFS_LOOPBACK_CONTROL: loopback_control[n] <= wdata & MASK_LOOPBACK_CONTROL;
            default: ;
          endcase
        end
      end

      // pointer distance report: live or peak-hold
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          rx_pointer_gap[n] <= 7'h00;
        end else if (!rx_jitter_atten_config[n][JA_REPORT_PEAK]) begin
          rx_pointer_gap[n] <= rx_fifo_distance[n];
        end else if (rx_fifo_distance[n] > rx_pointer_gap[n]) begin
          rx_pointer_gap[n] <= rx_fifo_distance[n];
        end
      end

      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          template_read_data[n] <= 7'h00;
        end else if (tmpl_fire && tmpl_read && 32'(acc_link) == n) begin
          template_read_data[n] <= template_ram[tmpl_index];
        end
      end

      // attenuator window: margin scales with depth
      logic [1:0] depth;
      logic [6:0] gap_top;
      logic [6:0] margin;
      logic near_edge;
      assign depth = rx_jitter_atten_config[n][JA_DEPTH_LSB +: 2];
      assign gap_top = depth == DEPTH_128 ? GAP_TOP_128 :
                       depth == DEPTH_64 ? GAP_TOP_64 : GAP_TOP_32;
      assign margin = depth == DEPTH_128 ? MARGIN_128 :
                      depth == DEPTH_64 ? MARGIN_64 : MARGIN_32;
      assign near_edge = rx_fifo_distance[n] <= margin
        || rx_fifo_distance[n] >= gap_top - margin;

      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          rx_atten_wide_now[n] <= 1'b0;
        end else begin
          rx_atten_wide_now[n] <= rx_jitter_atten_config[n][JA_ENABLE]
            && rx_jitter_atten_config[n][JA_WIDEN] && near_edge;
        end
      end

      // loss threshold, dB below nominal
      logic [4:0] los_code;
      logic [5:0] q_db;
      logic below;
      assign los_code = rx_path_config_1[n][LOS_THR_LSB +: LOS_THR_W];
      assign q_db = los_code >= LOS_CODE_FLOOR ? LOS_DB_FLOOR
        : LOS_DB_BASE + {los_code, 1'b0};
      // short haul uses its own fixed level; the code is ignored there
      assign below = rx_path_config_1[n][RX_EQUALIZER_ENABLE] ? rx_level_db[n] > q_db
        : rx_level_db[n] > SHORT_HAUL_LOSS_DB;

      logic [LOS_CNT_W-1:0] los_cnt;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          los_threshold_db[n] <= LOS_DB_BASE;
        end else begin
          los_threshold_db[n] <= q_db;
        end
      end

      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          los_cnt <= '0;
          loss_of_signal[n] <= 1'b0;
        end else if (pulse_tick[n]) begin
          if (!below) begin
            los_cnt <= '0;
            loss_of_signal[n] <= 1'b0;
          end else if (los_cnt < LOS_LIMIT) begin
            los_cnt <= los_cnt + 1'b1;
            loss_of_signal[n] <= los_cnt + 1'b1 >= LOS_LIMIT;
          end
        end
      end
    end else begin : g_absent
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          template_access[n] <= 8'h00;
          template_write_data[n] <= 8'h00;
          rx_jitter_atten_config[n] <= 8'h00;
          rx_path_config_0[n] <= 8'h00;
          rx_path_config_1[n] <= 8'h00;
          rx_path_config_2[n] <= 8'h00;
          loopback_control[n] <= 8'h00;
          rx_pointer_gap[n] <= 7'h00;
          template_read_data[n] <= 7'h00;
        end
      end
    end
  end

  // per-link config fields straight from the register flops
  for (genvar n = 0; n < LINKS; n++) begin : g_out
    assign rx_atten_enable[n] = rx_jitter_atten_config[n][JA_ENABLE];
    assign rx_atten_depth[n] = rx_jitter_atten_config[n][JA_DEPTH_LSB +: 2];
    assign rx_atten_corner[n] = rx_jitter_atten_config[n][JA_CORNER];
    assign rx_power_down[n] = rx_path_config_0[n][RX_POWER_OFF];
    assign rx_linecode_sel[n] = rx_path_config_0[n][RX_LINECODE];
    assign equalizer_enable[n] = rx_path_config_1[n][RX_EQUALIZER_ENABLE];
    assign slicer_level[n] = rx_path_config_2[n][SLICE_LSB +: 2];
    assign peak_window[n] = rx_path_config_2[n][PEAK_WIN_LSB +: 2];
    assign monitor_gain[n] = rx_path_config_2[n][MON_GAIN_LSB +: 2];
    assign local_digital_loop1[n] = loopback_control[n][LB_DIGITAL1];
    assign system_local_loop[n] = loopback_control[n][LB_SYS_LOCAL];
    assign system_remote_loop[n] = loopback_control[n][LB_SYS_REMOTE];
    assign line_remote_loop[n] = loopback_control[n][LB_LINE_REMOTE];
  end

  // read port: data one cycle after the strobe, zero for unmapped addresses
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = 8'h00;
    if (rd && link_ok) begin
      case (acc_ofs)
        OFS_TEMPLATE_ACCESS: next_rdata = template_access[acc_link];
        OFS_TEMPLATE_WRITE_DATA: next_rdata = template_write_data[acc_link];
        OFS_RX_JITTER_ATTEN_CONFIG: next_rdata = rx_jitter_atten_config[acc_link];
        OFS_RX_PATH_CONFIG_0: next_rdata = rx_path_config_0[acc_link];
        OFS_RX_PATH_CONFIG_1: next_rdata = rx_path_config_1[acc_link];
        OFS_RX_PATH_CONFIG_2: next_rdata = rx_path_config_2[acc_link];
        OFS_LOOPBACK_CONTROL: next_rdata = loopback_control[acc_link];
        OFS_RX_POINTER_GAP: next_rdata = {1'b0, rx_pointer_gap[acc_link]};
        OFS_TEMPLATE_READ_DATA: next_rdata = {1'b0, template_read_data[acc_link]};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else begin
      rdata <= next_rdata;
    end
  end

endmodule // lrc_regs

`default_nettype wire

// >>> verification/lrc_regs_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module lrc_regs_chk
  import lrc_pkg::*;
#(
  parameter int LINKS = MAX_LINKS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic [LINKS-1:0] pulse_tick,
  input wire logic [LINKS-1:0] rx_atten_enable,
  input wire logic [LINKS-1:0][1:0] rx_atten_depth,
  input wire logic [LINKS-1:0] rx_atten_corner,
  input wire logic [LINKS-1:0] rx_power_down,
  input wire logic [LINKS-1:0] rx_linecode_sel,
  input wire logic [LINKS-1:0] equalizer_enable,
  input wire logic [LINKS-1:0][5:0] los_threshold_db,
  input wire logic [LINKS-1:0] loss_of_signal,
  input wire logic [LINKS-1:0][1:0] slicer_level,
  input wire logic [LINKS-1:0][1:0] peak_window,
  input wire logic [LINKS-1:0][1:0] monitor_gain,
  input wire logic [LINKS-1:0] local_digital_loop1,
  input wire logic [LINKS-1:0] system_local_loop,
  input wire logic [LINKS-1:0] system_remote_loop,
  input wire logic [LINKS-1:0] line_remote_loop
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // only link 0 is watched, except the unmapped read at offset 30h on any link; the bench reads back the other links
  property p_unmapped;
    rd && addr[7:0] == 8'h30 |=> rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_atten;
    wr && addr == {3'h0, OFS_RX_JITTER_ATTEN_CONFIG} |=> rx_atten_enable[0] == $past(wdata[3])
      && rx_atten_depth[0] == $past(wdata[2:1]) && rx_atten_corner[0] == $past(wdata[0]);
  endproperty
  a_atten: assert property (p_atten) else $error("attenuator fields wrong");
  property p_cfg0;
    wr && addr == {3'h0, OFS_RX_PATH_CONFIG_0} |=> rx_power_down[0] == $past(wdata[4])
      && rx_linecode_sel[0] == $past(wdata[0]);
  endproperty
  a_cfg0: assert property (p_cfg0) else $error("power or line code wrong");
  property p_eq;
    wr && addr == {3'h0, OFS_RX_PATH_CONFIG_1} |=> equalizer_enable[0] == $past(wdata[6]);
  endproperty
  a_eq: assert property (p_eq) else $error("equalizer bit wrong");
  property p_thr;
    wr && addr == {3'h0, OFS_RX_PATH_CONFIG_1} |=> ##1 los_threshold_db[0] ==
      (($past(wdata[4:0], 2) >= 5'h16) ? 6'h30 : 6'(6'h04 + 2 * $past(wdata[4:0], 2)));
  endproperty
  a_thr: assert property (p_thr) else $error("threshold mapping wrong");
  property p_cfg2;
    wr && addr == {3'h0, OFS_RX_PATH_CONFIG_2} |=> slicer_level[0] == $past(wdata[5:4])
      && peak_window[0] == $past(wdata[3:2]) && monitor_gain[0] == $past(wdata[1:0]);
  endproperty
  a_cfg2: assert property (p_cfg2) else $error("slicer fields wrong");
  property p_loop;
    wr && addr == {3'h0, OFS_LOOPBACK_CONTROL} |=> local_digital_loop1[0] == $past(wdata[6])
      && system_local_loop[0] == $past(wdata[5]) && system_remote_loop[0] == $past(wdata[4])
      && line_remote_loop[0] == $past(wdata[2]);
  endproperty
  a_loop: assert property (p_loop) else $error("loopback bits wrong");
  property p_los_rise;
    $rose(loss_of_signal[0]) |-> $past(pulse_tick[0]);
  endproperty
  a_los_rise: assert property (p_los_rise) else $error("loss raised without tick");
endmodule // lrc_regs_chk
bind lrc_regs lrc_regs_chk #(.LINKS(LINKS)) i_chk (.*);
`default_nettype wire

// >>> verification/tb_lrc_regs.sv
`timescale 1ns/10ps
`default_nettype none
module tb_lrc_regs;
  import lrc_pkg::*;
  localparam int LN = 8;
  localparam logic [7:0] OFS [7] = '{OFS_TEMPLATE_ACCESS, OFS_TEMPLATE_WRITE_DATA,
    OFS_RX_JITTER_ATTEN_CONFIG, OFS_RX_PATH_CONFIG_0, OFS_RX_PATH_CONFIG_1,
    OFS_RX_PATH_CONFIG_2, OFS_LOOPBACK_CONTROL};
  localparam logic [7:0] MSK [7] = '{8'hff, 8'h7f, 8'h3f, 8'h11, 8'h5f, 8'h3f, 8'h74};
  localparam logic [7:0] RST [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h15, 8'h18, 8'h00};
  localparam logic [7:0] WC [9] = '{8'h18, 8'h18, 8'h18, 8'h18, 8'h1a, 8'h1a, 8'h1c, 8'h10, 8'h08};
  localparam logic [6:0] WD [9] = '{7'h04, 7'h05, 7'h7b, 7'h7a, 7'h03, 7'h04, 7'h1d, 7'h00, 7'h00};
  localparam logic [7:0] WE [9] = '{8'h01, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h00};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic [LN-1:0][3:0] pulse_shape_sel = {LN{4'hc}};
  logic [LN-1:0][6:0] rx_fifo_distance = '0;
  logic [LN-1:0][5:0] rx_level_db = '0;
  logic [LN-1:0] pulse_tick = '0;
  logic [LN-1:0] rx_atten_wide_now;
  logic [LN-1:0] loss_of_signal;
  logic [LN-1:0][5:0] los_threshold_db;
  logic [7:0] mem [LN][7];
  int mismatches = 0;
  int checks_done = 0;
  int seed = 72;
  lrc_regs #(.LINKS(LN), .LOS_INTERVALS(4)) i_dut (.clk, .rst_n, .addr, .wdata, .wr, .rd,
    .rdata, .pulse_shape_sel, .rx_fifo_distance, .rx_level_db, .pulse_tick,
    .rx_atten_enable(), .rx_atten_depth(), .rx_atten_corner(), .rx_atten_wide_now,
    .rx_power_down(), .rx_linecode_sel(), .equalizer_enable(), .los_threshold_db,
    .loss_of_signal, .slicer_level(), .peak_window(), .monitor_gain(),
    .local_digital_loop1(), .system_local_loop(), .system_remote_loop(), .line_remote_loop());
  always #5 clk = ~clk;
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic put(input logic [2:0] l, input logic [7:0] o, input logic [7:0] d);
    @(posedge clk);
    addr <= {l, o};
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic get(input logic [2:0] l, input logic [7:0] o, output logic [7:0] d);
    @(posedge clk);
    addr <= {l, o};
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // n one-cycle ticks per call, spaced so the count sees each interval separately
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      pulse_tick[0] <= 1'b1;
      @(posedge clk);
      pulse_tick[0] <= 1'b0;
    end
    idle(1);
  endtask
  function automatic logic [7:0] thr_db(input logic [4:0] c);
    return (c >= 5'h16) ? 8'h30 : 8'(8'h04 + 2 * c);
  endfunction
  initial begin
    // watchdog well beyond the cycle count of a full run
    #500us;
    mismatches++;
    wrap_up();
  end
  initial begin : main
    logic [7:0] v;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    for (int r = 0; r < 7; r++) begin
      get(3'h0, OFS[r], v);
      chk(v, RST[r]);
    end
    for (int k = 0; k < 2; k++) begin
      for (int l = 0; l < LN; l++) begin
        for (int r = 0; r < 7; r++) begin
          mem[l][r] = 8'($random(seed));
          put(3'(l), OFS[r], mem[l][r]);
        end
      end
      for (int l = 0; l < LN; l++) begin
        for (int r = 0; r < 7; r++) begin
          get(3'(l), OFS[r], v);
          chk(v, mem[l][r] & MSK[r]);
        end
      end
    end
    put(3'h0, 8'h30, 8'hff);
    get(3'h0, 8'h30, v);
    chk(v, 8'h00);
    for (int c = 0; c < 32; c++) begin
      put(3'h0, OFS_RX_PATH_CONFIG_1, 8'h40 | 8'(c));
      idle(1);
      chk({2'b00, los_threshold_db[0]}, thr_db(5'(c)));
    end
    put(3'h0, OFS_RX_PATH_CONFIG_1, 8'h40);
    rx_level_db[0] <= 6'd10;
    ticks(3);
    chk({7'h0, loss_of_signal[0]}, 8'h00);
    ticks(1);
    chk({7'h0, loss_of_signal[0]}, 8'h01);
    rx_level_db[0] <= 6'd2;
    ticks(1);
    chk({7'h0, loss_of_signal[0]}, 8'h00);
    put(3'h0, OFS_RX_PATH_CONFIG_1, 8'h00);
    rx_level_db[0] <= 6'd10;
    ticks(5);
    chk({7'h0, loss_of_signal[0]}, 8'h00);
    rx_level_db[0] <= 6'd30;
    ticks(4);
    chk({7'h0, loss_of_signal[0]}, 8'h01);
    put(3'h0, OFS_RX_JITTER_ATTEN_CONFIG, 8'h00);
    rx_fifo_distance[0] <= 7'd30;
    idle(2);
    get(3'h0, OFS_RX_POINTER_GAP, v);
    chk(v, 8'd30);
    put(3'h0, OFS_RX_JITTER_ATTEN_CONFIG, 8'h20);
    rx_fifo_distance[0] <= 7'd50;
    idle(2);
    get(3'h0, OFS_RX_POINTER_GAP, v);
    chk(v, 8'd50);
    rx_fifo_distance[0] <= 7'd20;
    idle(2);
    get(3'h0, OFS_RX_POINTER_GAP, v);
    chk(v, 8'd50);
    for (int i = 0; i < 9; i++) begin
      put(3'h0, OFS_RX_JITTER_ATTEN_CONFIG, WC[i]);
      rx_fifo_distance[0] <= WD[i];
      idle(2);
      chk({7'h0, rx_atten_wide_now[0]}, WE[i]);
    end
    for (int u = 0; u < 4; u++) begin
      put(3'h0, OFS_TEMPLATE_WRITE_DATA, 8'(8'h11 * u + 8'h05));
      put(3'h0, OFS_TEMPLATE_ACCESS, 8'(8'h80 | (u << 4) | (u * 5)));
    end
    put(3'h0, OFS_TEMPLATE_WRITE_DATA, 8'h7f);
    put(3'h0, OFS_TEMPLATE_ACCESS, 8'h15);
    pulse_shape_sel[0] <= 4'h0;
    put(3'h0, OFS_TEMPLATE_ACCESS, 8'h80);
    pulse_shape_sel[0] <= 4'hc;
    for (int u = 0; u < 4; u++) begin
      put(3'h0, OFS_TEMPLATE_ACCESS, 8'(8'hc0 | (u << 4) | (u * 5)));
      idle(1);
      get(3'h0, OFS_TEMPLATE_READ_DATA, v);
      chk(v, 8'(8'h11 * u + 8'h05));
    end
    wrap_up();
  end
endmodule // tb_lrc_regs
`default_nettype wire
